/* File: tsr_status_bank.sv */
// status read-back bank behind the two-wire serial slave transmitter
`timescale 1ns/100ps
module tsr_status_bank #(
	parameter int unsigned ERR_WINDOW = tsr_pkg::ERR_WINDOW_CYCLES,
	parameter logic [7:0] ID_SET_0 = 8'h11, // arbitrary value
	parameter logic [7:0] ID_SET_1 = 8'h22, // arbitrary value
	parameter logic [7:0] ID_SET_2 = 8'h33, // arbitrary value
	parameter logic [7:0] ID_SET_3 = 8'h44 // arbitrary value
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic gp_pin_one,
	input wire logic gp_pin_two,
	input wire logic [3:0] ctrl_bits,
	input wire logic sync_locked,
	input wire logic config_changed,
	input wire logic stereo_mode_flag,
	input wire logic dual_mono_flag,
	input wire logic digital_sound_present,
	input wire logic fm_dual_detected,
	input wire logic fm_stereo_detected,
	input wire logic automute_enable,
	input wire logic automute_trigger,
	input wire logic error_pulse,
	input wire logic extra_data_strobe,
	input wire logic [10:0] extra_data_word,
	input wire logic coding_ind_one,
	input wire logic coding_ind_two,
	output logic first_carrier_select,
	output logic automute_active,
	output logic digital_silence
);
	typedef struct packed {
		logic scl_meta, scl_sync, scl_prev;
		logic sda_meta, sda_sync, sda_prev;
		logic p1_meta, p1_sync, p2_meta, p2_sync;
		tsr_pkg::tsr_bus_st_t st;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic [7:0] sub;
		logic host_ack;
		logic drive;
		logic [10:0] xd_word;
		logic [1:0] ci;
		logic xd_new;
		logic xd_ovr;
		logic fallback;
	} tsr_bank_t;
	tsr_bank_t q, next_q;

	tsr_err_if eif ();
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic load_tx;
	logic [7:0] load_sub;
	logic [7:0] rd_data;
	logic [7:0] dev_status, sound_status, xd_high;
	logic xd_clear;

	// error counting over fixed windows lives in its own counter
	tsr_err_win #(.WINDOW_CYCLES(ERR_WINDOW)) u_err_win (
		.mclk(mclk),
		.rst_b(rst_b),
		.eif(eif.win)
	);
	assign eif.err_pulse = error_pulse;

	// bus edges and conditions, judged on the second and third stages only
	assign scl_rise = q.scl_sync && !q.scl_prev;
	assign scl_fall = !q.scl_sync && q.scl_prev;
	assign start_cond = q.scl_sync && q.scl_prev && !q.sda_sync && q.sda_prev;
	assign stop_cond = q.scl_sync && q.scl_prev && q.sda_sync && !q.sda_prev;

	// register images; undefined bits tie to zero
	always_comb begin
		dev_status = 8'h00;
		dev_status[tsr_pkg::DS_PIN_TWO] = q.p2_sync;
		dev_status[tsr_pkg::DS_PIN_ONE] = q.p1_sync;
		dev_status[tsr_pkg::DS_RESERVE] = ctrl_bits[3];
		dev_status[tsr_pkg::DS_AUTOMUTE] = q.fallback;
		dev_status[tsr_pkg::DS_DIGITAL] = digital_sound_present;
		dev_status[tsr_pkg::DS_FM_DUAL] = fm_dual_detected;
		dev_status[tsr_pkg::DS_FM_STEREO] = fm_stereo_detected;
		sound_status = {ctrl_bits, sync_locked, config_changed,
			stereo_mode_flag, dual_mono_flag};
		xd_high = {q.xd_ovr, q.xd_new, 1'b0, q.ci, q.xd_word[10:8]};
	end

	// read multiplexer; anything not held here answers all ones
	always_comb begin
		case (load_sub)
			tsr_pkg::SUB_DEV_STATUS: rd_data = dev_status;
			tsr_pkg::SUB_SOUND_STATUS: rd_data = sound_status;
			tsr_pkg::SUB_ERROR_COUNT: rd_data = eif.count;
			tsr_pkg::SUB_XDATA_LOW: rd_data = q.xd_word[7:0];
			tsr_pkg::SUB_XDATA_HIGH: rd_data = xd_high;
			tsr_pkg::SUB_ID_FIRST: rd_data = ID_SET_0;
			tsr_pkg::SUB_ID_FIRST + 8'h01: rd_data = ID_SET_1;
			tsr_pkg::SUB_ID_FIRST + 8'h02: rd_data = ID_SET_2;
			tsr_pkg::SUB_ID_LAST: rd_data = ID_SET_3;
			default: rd_data = tsr_pkg::UNMAPPED_BYTE;
		endcase
	end

	// a byte load happens right after a read address ack or after a host ack
	always_comb begin
		load_tx = 1'b0;
		load_sub = q.sub;
		if (scl_fall && q.st == tsr_pkg::TSR_ADDR_ACK && q.shreg[0]) begin
			load_tx = 1'b1;
		end else if (scl_fall && q.st == tsr_pkg::TSR_RACK && q.host_ack) begin
			load_tx = 1'b1;
			load_sub = q.sub + 8'h01;
		end
	end
	assign xd_clear = load_tx && load_sub == tsr_pkg::SUB_XDATA_HIGH;

	// bus engine plus the data and status flags, all on mclk
	always_comb begin
		next_q = q;
		// two-stage synchronisers for pins, third stage only for edges
		next_q.scl_meta = scl_in;
		next_q.scl_sync = q.scl_meta;
		next_q.scl_prev = q.scl_sync;
		next_q.sda_meta = sda_in;
		next_q.sda_sync = q.sda_meta;
		next_q.sda_prev = q.sda_sync;
		next_q.p1_meta = gp_pin_one;
		next_q.p1_sync = q.p1_meta;
		next_q.p2_meta = gp_pin_two;
		next_q.p2_sync = q.p2_meta;
		// fallback to first carrier; forced cases ignore the enable
		next_q.fallback = ctrl_bits[2] || !sync_locked ||
			(automute_enable && automute_trigger);
		// extra data store; a new store wins over a read clear
		if (extra_data_strobe) begin
			next_q.xd_word = extra_data_word;
			next_q.ci = {coding_ind_one, coding_ind_two};
			next_q.xd_new = 1'b1;
			next_q.xd_ovr = q.xd_ovr || (q.xd_new && !xd_clear);
		end else if (xd_clear) begin
			next_q.xd_new = 1'b0;
			next_q.xd_ovr = 1'b0;
		end
		if (load_tx) begin
			next_q.tx = rd_data;
			next_q.sub = load_sub;
		end
		if (start_cond) begin
			next_q.st = tsr_pkg::TSR_ADDR;
			next_q.cnt = 4'h0;
			next_q.drive = 1'b0;
		end else if (stop_cond) begin
			next_q.st = tsr_pkg::TSR_IDLE;
			next_q.drive = 1'b0;
		end else begin
			case (q.st)
				tsr_pkg::TSR_IDLE: begin
					next_q.drive = 1'b0;
				end
				tsr_pkg::TSR_ADDR, tsr_pkg::TSR_SUB, tsr_pkg::TSR_WDATA: begin
					if (scl_rise) begin
						next_q.shreg = {q.shreg[6:0], q.sda_sync};
						next_q.cnt = q.cnt + 4'h1;
					end else if (scl_fall && q.cnt == tsr_pkg::BITS_PER_BYTE) begin
						next_q.cnt = 4'h0;
						next_q.drive = 1'b1;
						if (q.st == tsr_pkg::TSR_ADDR) begin
							// foreign address: stay off the bus until the next start
							if (q.shreg[7:1] == tsr_pkg::SLAVE_ADDR) begin
								next_q.st = tsr_pkg::TSR_ADDR_ACK;
							end else begin
								next_q.st = tsr_pkg::TSR_IDLE;
								next_q.drive = 1'b0;
							end
						end else if (q.st == tsr_pkg::TSR_SUB) begin
							next_q.st = tsr_pkg::TSR_SUB_ACK;
							next_q.sub = q.shreg;
						end else begin
							next_q.st = tsr_pkg::TSR_WDATA_ACK;
						end
					end
				end
				tsr_pkg::TSR_ADDR_ACK: begin
					if (scl_fall) begin
						if (q.shreg[0]) begin
							next_q.st = tsr_pkg::TSR_RDATA;
							next_q.drive = !rd_data[7];
						end else begin
							next_q.st = tsr_pkg::TSR_SUB;
							next_q.drive = 1'b0;
						end
					end
				end
				tsr_pkg::TSR_SUB_ACK, tsr_pkg::TSR_WDATA_ACK: begin
					// written bytes are acked and dropped: this bank is read-only
					if (scl_fall) begin
						next_q.st = tsr_pkg::TSR_WDATA;
						next_q.drive = 1'b0;
					end
				end
				tsr_pkg::TSR_RDATA: begin
					if (scl_rise) begin
						next_q.cnt = q.cnt + 4'h1;
					end else if (scl_fall) begin
						if (q.cnt == tsr_pkg::BITS_PER_BYTE) begin
							next_q.st = tsr_pkg::TSR_RACK;
							next_q.cnt = 4'h0;
							next_q.drive = 1'b0;
						end else begin
							next_q.tx = {q.tx[6:0], 1'b0};
							next_q.drive = !q.tx[6];
						end
					end
				end
				tsr_pkg::TSR_RACK: begin
					if (scl_rise) begin
						next_q.host_ack = !q.sda_sync;
					end else if (scl_fall) begin
						// a nack ends the read; wait for stop or repeated start
						if (q.host_ack) begin
							next_q.st = tsr_pkg::TSR_RDATA;
							next_q.drive = !rd_data[7];
						end else begin
							next_q.st = tsr_pkg::TSR_IDLE;
						end
					end
				end
				default: begin
					next_q.st = tsr_pkg::TSR_IDLE;
					next_q.drive = 1'b0;
				end
			endcase
		end
	end

	// all state in one register; lines idle high after reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			q <= '0;
			q.scl_meta <= 1'b1;
			q.scl_sync <= 1'b1;
			q.scl_prev <= 1'b1;
			q.sda_meta <= 1'b1;
			q.sda_sync <= 1'b1;
			q.sda_prev <= 1'b1;
			q.st <= tsr_pkg::TSR_IDLE;
			q.fallback <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// open-drain data line: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = q.drive;
	assign first_carrier_select = q.fallback;
	assign automute_active = q.fallback;
	assign digital_silence = !sync_locked;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// captured bytes are checked one cycle after capture, against the sources
	// as they stood at the capturing edge
	a_pin_two_bit: assert property (load_tx && load_sub == tsr_pkg::SUB_DEV_STATUS
		|=> q.tx[tsr_pkg::DS_PIN_TWO] == $past(q.p2_sync))
		else $error("status bit 7 not port pin two");
	a_pin_one_bit: assert property (load_tx && load_sub == tsr_pkg::SUB_DEV_STATUS
		|=> q.tx[tsr_pkg::DS_PIN_ONE] == $past(q.p1_sync))
		else $error("status bit 6 not port pin one");
	a_reserve_bit: assert property (load_tx && load_sub == tsr_pkg::SUB_DEV_STATUS
		|=> q.tx[tsr_pkg::DS_RESERVE] == $past(ctrl_bits[3]))
		else $error("status bit 5 not control bit four");
	a_status_spare: assert property (load_tx && load_sub == tsr_pkg::SUB_DEV_STATUS
		|=> q.tx[0] == 1'b0)
		else $error("undefined status bit not zero");
	a_sound_byte: assert property (load_tx
		&& load_sub == tsr_pkg::SUB_SOUND_STATUS
		|=> q.tx[7:4] == $past(ctrl_bits) && q.tx[3] == $past(sync_locked))
		else $error("sound status byte wrong");
	a_ctrl_three_fb: assert property (ctrl_bits[2] |=> first_carrier_select)
		else $error("control bit three did not force first carrier");
	a_sync_loss_fb: assert property (!sync_locked |=> automute_active)
		else $error("sync loss did not force first carrier");
	a_new_flag_set: assert property (extra_data_strobe |=> q.xd_new)
		else $error("new data flag not set on store");
	a_overrun_set: assert property (extra_data_strobe && q.xd_new && !xd_clear
		|=> q.xd_ovr)
		else $error("overrun not flagged");
	// the captured byte still shows the flag as it stood before the clear
	a_read_clears: assert property (xd_clear && !extra_data_strobe
		|=> !q.xd_new && !q.xd_ovr && q.tx[tsr_pkg::XH_NEW] == $past(q.xd_new))
		else $error("read did not clear new data flag");
	a_low_data: assert property (load_tx && load_sub == tsr_pkg::SUB_XDATA_LOW
		|=> q.tx == $past(q.xd_word[7:0]))
		else $error("low extra data byte wrong");
	a_high_data: assert property (load_tx
		&& load_sub == tsr_pkg::SUB_XDATA_HIGH
		|=> q.tx[2:0] == $past(q.xd_word[10:8]) && q.tx[5] == 1'b0)
		else $error("high extra data bits wrong");
	a_unmapped_ff: assert property (load_tx && load_sub > tsr_pkg::SUB_XDATA_HIGH
		&& load_sub < tsr_pkg::SUB_ID_FIRST |=> q.tx == tsr_pkg::UNMAPPED_BYTE)
		else $error("unmapped subaddress not all ones");
	a_id_last: assert property (load_tx && load_sub == tsr_pkg::SUB_ID_LAST
		|=> q.tx == ID_SET_3)
		else $error("last identification byte wrong");
	a_sub_wrap: assert property (load_tx && q.st == tsr_pkg::TSR_RACK
		&& q.sub == 8'hff
		|=> q.sub == 8'h00 && q.st == tsr_pkg::TSR_RDATA)
		else $error("subaddress did not wrap to zero");
	a_nack_idle: assert property (q.st == tsr_pkg::TSR_RACK
		&& scl_fall && !q.host_ack |=> q.st == tsr_pkg::TSR_IDLE)
		else $error("host nack did not end the read");
	a_byte_stable: assert property (q.st == tsr_pkg::TSR_RDATA
		&& !scl_fall && !load_tx |=> q.tx == $past(q.tx))
		else $error("read byte changed mid shift");
endmodule // tsr_status_bank

/* File: tsr_pkg.sv */
// constants and types shared by the status read-back bank
package tsr_pkg;
	// register subaddresses
	localparam logic [7:0] SUB_DEV_STATUS = 8'h00;
	localparam logic [7:0] SUB_SOUND_STATUS = 8'h01;
	localparam logic [7:0] SUB_ERROR_COUNT = 8'h02;
	localparam logic [7:0] SUB_XDATA_LOW = 8'h03;
	localparam logic [7:0] SUB_XDATA_HIGH = 8'h04;
	localparam logic [7:0] SUB_ID_FIRST = 8'hfc;
	localparam logic [7:0] SUB_ID_LAST = 8'hff;
	localparam logic [7:0] UNMAPPED_BYTE = 8'hff;
	// field positions in the device status register
	localparam int DS_PIN_TWO = 7;
	localparam int DS_PIN_ONE = 6;
	localparam int DS_RESERVE = 5;
	localparam int DS_AUTOMUTE = 4;
	localparam int DS_DIGITAL = 3;
	localparam int DS_FM_DUAL = 2;
	localparam int DS_FM_STEREO = 1;
	// field positions in the extra data high register
	localparam int XH_OVERRUN = 7;
	localparam int XH_NEW = 6;
	// bus details
	localparam logic [6:0] SLAVE_ADDR = 7'h5c;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// error window timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int ERR_WINDOW_MS = 128;
	localparam int ERR_WINDOW_CYCLES = (ERR_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
	localparam int ERR_CNT_W = 25;
	typedef enum logic [3:0] {
		TSR_IDLE, TSR_ADDR, TSR_ADDR_ACK, TSR_SUB, TSR_SUB_ACK,
		TSR_WDATA, TSR_WDATA_ACK, TSR_RDATA, TSR_RACK
	} tsr_bus_st_t;
endpackage

/* File: tsr_err_if.sv */
// signals between the bus bank and the error window counter
`timescale 1ns/100ps
interface tsr_err_if;
	logic err_pulse;
	logic [7:0] count;
	logic refresh;
	modport bank (output err_pulse, input count, input refresh);
	modport win (input err_pulse, output count, output refresh);
endinterface

/* File: tsr_err_win.sv */
// windowed error counter: latches the count of each closed window
`timescale 1ns/100ps
module tsr_err_win #(
	parameter int unsigned WINDOW_CYCLES = tsr_pkg::ERR_WINDOW_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	tsr_err_if.win eif
);
	typedef struct packed {
		logic [tsr_pkg::ERR_CNT_W-1:0] tick;
		logic [7:0] run;
		logic [7:0] held;
		logic refresh;
	} tsr_win_t;
	tsr_win_t q, next_q;
	logic [tsr_pkg::ERR_CNT_W-1:0] last_tick;
	logic [7:0] run_inc;

	// saturate so a noisy window reads full scale, not a wrapped small value
	always_comb begin
		last_tick = tsr_pkg::ERR_CNT_W'(WINDOW_CYCLES - 1);
		run_inc = (eif.err_pulse && q.run != 8'hff) ? q.run + 8'h01 : q.run;
		next_q = q;
		next_q.refresh = 1'b0;
		if (q.tick == last_tick) begin
			next_q.tick = '0;
			next_q.held = run_inc;
			next_q.run = 8'h00;
			next_q.refresh = 1'b1;
		end else begin
			next_q.tick = q.tick + 1'b1;
			next_q.run = run_inc;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign eif.count = q.held;
	assign eif.refresh = q.refresh;

	a_window_period: assert property (@(posedge mclk) disable iff (!rst_b)
		q.refresh |-> q.tick == '0 && $past(q.tick) == last_tick)
		else $error("error window refreshed off period");
endmodule // tsr_err_win

/* File: tsr_host.sv */
// serial bus master model standing in for the host controller
`timescale 1ns/100ps
module tsr_host (
	input wire logic sda_line,
	output logic scl_out,
	output logic sda_pull
);
	logic [7:0] rd [8];
	logic nak;
	// both lines released while idle; the pull-up lifts sda
	initial begin
		scl_out = 1'b1;
		sda_pull = 1'b0;
	end
	// one bit: data set while scl low, held until after the scl fall
	task automatic put_bit(input logic b);
		sda_pull = !b;
		#40 scl_out = 1'b1;
		#80 scl_out = 1'b0;
		#40;
	endtask
	// sample in the middle of the high phase, after the device has settled
	task automatic get_bit(output logic b);
		sda_pull = 1'b0;
		#40 scl_out = 1'b1;
		#40 b = sda_line;
		#40 scl_out = 1'b0;
		#40;
	endtask
	task automatic send_byte(input logic [7:0] v, output logic ack_n);
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(ack_n);
	endtask
	// start or repeated start: sda falls while scl high
	task automatic start_cond;
		sda_pull = 1'b0;
		#40 scl_out = 1'b1;
		#40 sda_pull = 1'b1;
		#40 scl_out = 1'b0;
		#40;
	endtask
	task automatic stop_cond;
		sda_pull = 1'b1;
		#40 scl_out = 1'b1;
		#40 sda_pull = 1'b0;
		#40;
	endtask
	// address a foreign or own slave and report whether anyone acked
	task automatic probe(input logic [6:0] a, output logic ack_n);
		start_cond;
		send_byte({a, 1'b0}, ack_n);
		stop_cond;
	endtask
	// subaddress write, repeated start, then n bytes read back
	task automatic read_regs(input logic [7:0] sub, input int n);
		logic a;
		logic b;
		nak = 1'b0;
		start_cond;
		send_byte({tsr_pkg::SLAVE_ADDR, 1'b0}, a);
		nak |= a;
		send_byte(sub, a);
		nak |= a;
		start_cond;
		send_byte({tsr_pkg::SLAVE_ADDR, 1'b1}, a);
		nak |= a;
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				get_bit(b);
				rd[k][i] = b;
			end
			put_bit(k == n - 1);
		end
		stop_cond;
	endtask
endmodule // tsr_host

/* File: testbench.sv */
// self-checking bench for the status read-back bank
`timescale 1ns/100ps
module testbench;
	typedef struct packed {
		logic [1:0] pins;
		logic [3:0] ctrl;
		logic [8:0] misc;
		logic fcs;
		logic [7:0] exp0;
		logic [7:0] exp1;
	} tsr_row_t;
	logic mclk, rst_b, scl, sda, sda_out, sda_oe, sda_pull, xs, err_run, error_pulse, a;
	logic fcs, am_act, dsil;
	logic [1:0] pins, ci, err_ph;
	logic [3:0] ctrl;
	logic [8:0] misc;
	logic [10:0] xw;
	int errors, check_count;
	// pins, ctrl bits, {sync,cfc,stereo,dual,digital,fm dual,fm stereo,am en,am trig}
	tsr_row_t rows [5] = '{
		'{2'h2, 4'h8, 9'h155, 1'h0, 8'haa, 8'h8a},
		'{2'h1, 4'h4, 9'h1a8, 1'h1, 8'h54, 8'h4d},
		'{2'h3, 4'h0, 9'h000, 1'h1, 8'hd0, 8'h00},
		'{2'h0, 4'h3, 9'h113, 1'h1, 8'h18, 8'h38},
		'{2'h0, 4'h0, 9'h102, 1'h0, 8'h00, 8'h08}};
	logic [7:0] wrap_exp [9] = '{8'hff, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'hff, 8'hff, 8'hff};
	// open-drain sda with pull-up, both parties may pull low
	assign sda = (sda_oe ? sda_out : 1'b1) && !sda_pull;
	tsr_host host (.sda_line(sda), .scl_out(scl), .sda_pull(sda_pull));
	tsr_status_bank #(.ERR_WINDOW(200)) uut (
		.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .gp_pin_one(pins[0]), .gp_pin_two(pins[1]), .ctrl_bits(ctrl),
		.sync_locked(misc[8]), .config_changed(misc[7]), .stereo_mode_flag(misc[6]),
		.dual_mono_flag(misc[5]), .digital_sound_present(misc[4]),
		.fm_dual_detected(misc[3]), .fm_stereo_detected(misc[2]),
		.automute_enable(misc[1]), .automute_trigger(misc[0]), .error_pulse(error_pulse),
		.extra_data_strobe(xs), .extra_data_word(xw), .coding_ind_one(ci[1]),
		.coding_ind_two(ci[0]), .first_carrier_select(fcs), .automute_active(am_act),
		.digital_silence(dsil));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// one error every fourth cycle: any 200-cycle window holds exactly 50
	always @(negedge mclk) begin
		if (!rst_b) begin
			err_ph <= 2'h0;
			error_pulse <= 1'b0;
		end else begin
			err_ph <= err_ph + 2'h1;
			error_pulse <= err_run && (err_ph == 2'h0);
		end
	end
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic store_extra(input logic [10:0] w, input logic [1:0] c);
		@(negedge mclk);
		xw = w;
		ci = c;
		xs = 1'b1;
		@(negedge mclk);
		xs = 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, well past the expected length of the run
	initial begin
		#300000;
		errors++;
		give_verdict;
	end
	initial begin
		rst_b = 1'b0;
		{pins, ctrl, misc, ci, xw, xs, err_run} = '0;
		repeat (8) @(negedge mclk);
		check_bit("sda_oe in reset", 1'h0, sda_oe);
		check_bit("fallback in reset", 1'h1, fcs);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		// ordinary cases: status inputs in, both status bytes read back
		foreach (rows[r]) begin
			@(negedge mclk);
			{pins, ctrl, misc} = {rows[r].pins, rows[r].ctrl, rows[r].misc};
			repeat (4) @(negedge mclk);
			check_bit("first_carrier", rows[r].fcs, fcs);
			check_bit("automute_active", rows[r].fcs, am_act);
			check_bit("silence", !rows[r].misc[8], dsil);
			host.read_regs(8'h00, 2);
			check_byte("device_status", rows[r].exp0, host.rd[0]);
			check_byte("sound_status", rows[r].exp1, host.rd[1]);
			check_bit("acks", 1'h0, host.nak);
		end
		// extra data: single store, then a read clears the new flag
		store_extra(11'h5a3, 2'h2);
		host.read_regs(8'h03, 2);
		check_byte("extra_low", 8'ha3, host.rd[0]);
		check_byte("extra_high", 8'h55, host.rd[1]);
		host.read_regs(8'h04, 1);
		check_byte("extra_high read", 8'h15, host.rd[0]);
		// two stores with no read between them must flag an overrun
		store_extra(11'h1ff, 2'h0);
		store_extra(11'h2c4, 2'h1);
		host.read_regs(8'h03, 2);
		check_byte("extra_low 2", 8'hc4, host.rd[0]);
		check_byte("overrun", 8'hca, host.rd[1]);
		host.read_regs(8'h04, 1);
		check_byte("overrun read", 8'h0a, host.rd[0]);
		// error count of the previous window, then an empty window
		@(negedge mclk);
		err_run = 1'b1;
		repeat (450) @(negedge mclk);
		host.read_regs(8'h02, 1);
		check_byte("error_count", 8'h32, host.rd[0]);
		@(negedge mclk);
		err_run = 1'b0;
		host.read_regs(8'h02, 1);
		check_byte("error_count idle", 8'h00, host.rd[0]);
		// wrap from 255 to 0 through the id set, then unmapped 5..7
		host.read_regs(8'hfb, 6);
		for (int i = 0; i < 6; i++) check_byte("wrap read", wrap_exp[i], host.rd[i]);
		host.read_regs(8'h05, 3);
		for (int i = 0; i < 3; i++) check_byte("unmapped", wrap_exp[6 + i], host.rd[i]);
		// a foreign slave address gets no acknowledge
		host.probe(tsr_pkg::SLAVE_ADDR ^ 7'h01, a);
		check_bit("foreign ack", 1'h1, a);
		give_verdict;
	end
endmodule // testbench
